/* socs_pkg.sv */
// Package with register map, selection codes and reset values for the output condition selector.
package socs_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] SOCS_SEL_OFF    = 8'h00;
  localparam logic [7:0] SOCS_ZERO_OFF   = 8'h04;
  localparam logic [7:0] SOCS_BAND_OFF   = 8'h08;
  localparam logic [7:0] SOCS_SETPT_OFF  = 8'h0C;
  localparam logic [7:0] SOCS_OVLD_OFF   = 8'h10;
  localparam logic [7:0] SOCS_UNLD_OFF   = 8'h14;
  localparam logic [7:0] SOCS_PERR_OFF   = 8'h18;
  localparam logic [7:0] SOCS_POSTOL_OFF = 8'h1C;
  localparam logic [7:0] SOCS_STAT_OFF   = 8'h20;
  localparam logic [7:0] SOCS_COND_OFF   = 8'h24;

  // Reset values.
  localparam logic [4:0]  SOCS_SEL_RST = 5'h00;
  localparam logic [15:0] SOCS_THR_RST = 16'h0000;

  // Full scale of the remaining overload capacity, meaning one hundred percent.
  localparam logic [15:0] SOCS_OVL_FULL = 16'h0064;

  // Number of cycles the contactor output leads run and trails stop.
  localparam int SOCS_CONT_DELAY_NS = 100000;
  localparam int SOCS_CLK_NS        = 50;
  localparam int SOCS_CONT_CYC      = (SOCS_CONT_DELAY_NS + SOCS_CLK_NS - 1) / SOCS_CLK_NS;

  // Selection codes.
  typedef enum logic [4:0] {
    SOCS_SEL_ZERO_SPD  = 5'h08,
    SOCS_SEL_AT_SPD    = 5'h09,
    SOCS_SEL_SET_SPD   = 5'h0A,
    SOCS_SEL_OVER_CUR  = 5'h0B,
    SOCS_SEL_UNDER_CUR = 5'h0C,
    SOCS_SEL_OVL_CAP   = 5'h0D,
    SOCS_SEL_KEYPAD    = 5'h0E,
    SOCS_SEL_BRAKE     = 5'h0F,
    SOCS_SEL_FOLDBACK  = 5'h10,
    SOCS_SEL_FAULT     = 5'h11,
    SOCS_SEL_ALARM     = 5'h12,
    SOCS_SEL_CMD_FWD   = 5'h13,
    SOCS_SEL_CMD_REV   = 5'h14,
    SOCS_SEL_MOT_FWD   = 5'h15,
    SOCS_SEL_MOT_REV   = 5'h16,
    SOCS_SEL_PROC_ERR  = 5'h17,
    SOCS_SEL_AT_POS    = 5'h19,
    SOCS_SEL_IN_MOTION = 5'h1A,
    SOCS_SEL_PLC       = 5'h1B,
    SOCS_SEL_RTC       = 5'h1C,
    SOCS_SEL_BUS_UP    = 5'h1D,
    SOCS_SEL_HEATER    = 5'h1E,
    SOCS_SEL_CONTACTOR = 5'h1F
  } socs_sel_t;

  // Contactor sequencer states.
  typedef enum logic [1:0] {
    SOCS_CT_OPEN    = 2'b00,
    SOCS_CT_CLOSING = 2'b01,
    SOCS_CT_CLOSED  = 2'b10,
    SOCS_CT_OPENING = 2'b11
  } socs_ct_state_t;

endpackage

/* socs_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
module socs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage, so a metastable level never fans out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

/* socs_top.sv */
// Programmable digital output condition selector with a Wishbone register slave.
//
// How it works
// - code 8: speed below zero-speed threshold.
// - code 9: speed inside band around command.
// - code 10: speed at or above set point.
// - code 11: current above overload set point.
// - code 12: current below underload set point.
// - code 13: overload capacity below one hundred percent.
// - code 14: drive under local keypad control.
// - code 15: follows braking transistor on state.
// - code 16: foldback active, volts-per-hertz only.
// - code 17: fault present, which trips drive.
// - code 18: alarm present, no trip.
// - code 19: forward run command applied.
// - code 20: reverse run command applied.
// - code 21: motor turning forward.
// - code 22: motor turning reverse.
// - code 23: process error magnitude above tolerance.
// - code 25: position and speed both settled.
// - code 26: position or speed outside tolerance.
// - codes 27, 28: PLC or RTC drives output.
// - code 29: bus up and no fault.
// - code 30: trickle heating active.
// - code 31: sequenced motor contactor control.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module socs_top
  import socs_pkg::*;
#(
  parameter int          W           = 16,
  parameter int unsigned CONT_CYCLES = SOCS_CONT_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone classic slave.
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // Drive measurements, same clock domain, two's complement except the unsigned overload_left_i.
  input  wire logic signed [W-1:0] motor_speed_i,
  input  wire logic signed [W-1:0] speed_cmd_i,
  input  wire logic signed [W-1:0] motor_current_i,
  input  wire logic signed [W-1:0] process_err_i,
  input  wire logic signed [W-1:0] position_err_i,
  input  wire logic        [W-1:0] overload_left_i,
  // Drive status levels, same clock domain.
  input  wire logic                keypad_ctl_i,
  input  wire logic                brake_on_i,
  input  wire logic                foldback_i,
  input  wire logic                vhz_mode_i,
  input  wire logic                fault_i,
  input  wire logic                alarm_i,
  input  wire logic                cmd_fwd_i,
  input  wire logic                cmd_rev_i,
  input  wire logic                plc_out_i,
  input  wire logic                heater_on_i,
  input  wire logic                drive_run_i,
  // Levels from outside the clock domain.
  input  wire logic                rtc_out_i,
  input  wire logic                bus_up_i,
  // Programmable output and contactor enable feedback to the drive.
  output logic                     out_o,
  output logic                     run_permit_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [4:0]   sel_q;
  logic [W-1:0] zero_speed_threshold_q;
  logic [W-1:0] speed_match_band_q;
  logic [W-1:0] set_speed_q;
  logic [W-1:0] overload_sp_q;
  logic [W-1:0] underload_sp_q;
  logic [W-1:0] proc_tol_q;
  logic [W-1:0] pos_tol_q;
  logic         ack_q;
  logic [31:0]  rdat_q;
  logic         out_q;
  logic [22:0]  cond_q;

  wire req     = cyc_i & stb_i & ~ack_q;
  wire wr_stb  = req & we_i;

  // Writes a 32-bit register field honouring byte lanes; only the low W bits are kept.
  function automatic logic [W-1:0] wb_merge(input logic [W-1:0] old);
    logic [31:0] tmp;
    tmp = 32'(old);
    for (int b = 0; b < 4; b++) begin
      if (sel_i[b]) begin
        tmp[b*8 +: 8] = dat_i[b*8 +: 8];
      end
    end
    return tmp[W-1:0];
  endfunction

  // Configuration writes take effect on the edge where ack is raised.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q                  <= SOCS_SEL_RST;
      zero_speed_threshold_q <= W'(SOCS_THR_RST);
      speed_match_band_q     <= W'(SOCS_THR_RST);
      set_speed_q            <= W'(SOCS_THR_RST);
      overload_sp_q          <= W'(SOCS_THR_RST);
      underload_sp_q         <= W'(SOCS_THR_RST);
      proc_tol_q             <= W'(SOCS_THR_RST);
      pos_tol_q              <= W'(SOCS_THR_RST);
    end else if (wr_stb) begin
      unique case (adr_i)
        SOCS_SEL_OFF: begin
          if (sel_i[0]) begin
            sel_q <= dat_i[4:0];
          end
        end
        SOCS_ZERO_OFF:   zero_speed_threshold_q <= wb_merge(zero_speed_threshold_q);
        SOCS_BAND_OFF:   speed_match_band_q     <= wb_merge(speed_match_band_q);
        SOCS_SETPT_OFF:  set_speed_q            <= wb_merge(set_speed_q);
        SOCS_OVLD_OFF:   overload_sp_q          <= wb_merge(overload_sp_q);
        SOCS_UNLD_OFF:   underload_sp_q         <= wb_merge(underload_sp_q);
        SOCS_PERR_OFF:   proc_tol_q             <= wb_merge(proc_tol_q);
        SOCS_POSTOL_OFF: pos_tol_q              <= wb_merge(pos_tol_q);
        default: begin
        end
      endcase
    end
  end

  // One-cycle ack for every access, mapped or not; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        unique case (adr_i)
          SOCS_SEL_OFF:    rdat_q <= 32'(sel_q);
          SOCS_ZERO_OFF:   rdat_q <= 32'(zero_speed_threshold_q);
          SOCS_BAND_OFF:   rdat_q <= 32'(speed_match_band_q);
          SOCS_SETPT_OFF:  rdat_q <= 32'(set_speed_q);
          SOCS_OVLD_OFF:   rdat_q <= 32'(overload_sp_q);
          SOCS_UNLD_OFF:   rdat_q <= 32'(underload_sp_q);
          SOCS_PERR_OFF:   rdat_q <= 32'(proc_tol_q);
          SOCS_POSTOL_OFF: rdat_q <= 32'(pos_tol_q);
          SOCS_STAT_OFF:   rdat_q <= {30'h0000_0000, run_permit_o, out_q};
          SOCS_COND_OFF:   rdat_q <= {9'h000, cond_q};
          default:         rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  logic [1:0] async_s;

  // The RTC module and bus monitor sit outside this clock domain.
  socs_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i  ({bus_up_i, rtc_out_i}),
    .q_o  (async_s)
  );

  wire rtc_s    = async_s[0];
  wire bus_up_s = async_s[1];

  // Magnitudes; the most negative value keeps its own bit pattern, which read unsigned is its true magnitude.
  function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
    return v[W-1] ? W'(-v) : W'(v);
  endfunction

  logic [W-1:0] speed_mag;
  logic [W-1:0] perr_mag;
  logic [W-1:0] pos_mag;
  logic signed [W:0] speed_diff;
  logic [W:0]   diff_mag;

  always_comb begin
    speed_mag  = mag(motor_speed_i);
    perr_mag   = mag(process_err_i);
    pos_mag    = mag(position_err_i);
    speed_diff = (W+1)'(motor_speed_i) - (W+1)'(speed_cmd_i);
    diff_mag   = speed_diff[W] ? (W+1)'(-speed_diff) : (W+1)'(speed_diff);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Contactor sequencing.

  socs_ct_state_t ct_q;
  logic [31:0]    ct_cnt_q;
  logic           ct_close_q;

  // The contactor closes before the drive may run and opens only after it has stopped,
  // so the contacts never make or break motor current.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ct_q       <= SOCS_CT_OPEN;
      ct_cnt_q   <= 32'h0000_0000;
      ct_close_q <= 1'b0;
    end else begin
      unique case (ct_q)
        SOCS_CT_OPEN: begin
          ct_cnt_q <= 32'h0000_0000;
          if (cmd_fwd_i || cmd_rev_i) begin
            ct_q       <= SOCS_CT_CLOSING;
            ct_close_q <= 1'b1;
          end
        end
        SOCS_CT_CLOSING: begin
          if (ct_cnt_q >= CONT_CYCLES - 1) begin
            ct_q     <= SOCS_CT_CLOSED;
            ct_cnt_q <= 32'h0000_0000;
          end else begin
            ct_cnt_q <= ct_cnt_q + 32'h0000_0001;
          end
        end
        SOCS_CT_CLOSED: begin
          if (!cmd_fwd_i && !cmd_rev_i && !drive_run_i) begin
            ct_q <= SOCS_CT_OPENING;
          end
        end
        SOCS_CT_OPENING: begin
          if (cmd_fwd_i || cmd_rev_i) begin
            ct_q     <= SOCS_CT_CLOSED;
            ct_cnt_q <= 32'h0000_0000;
          end else if (ct_cnt_q >= CONT_CYCLES - 1) begin
            ct_q       <= SOCS_CT_OPEN;
            ct_close_q <= 1'b0;
            ct_cnt_q   <= 32'h0000_0000;
          end else begin
            ct_cnt_q <= ct_cnt_q + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // With the contactor code selected, running is only permitted once the contactor has settled closed; otherwise always.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_permit_o <= 1'b0;
    end else begin
      run_permit_o <= (sel_q != SOCS_SEL_CONTACTOR) || (ct_q == SOCS_CT_CLOSED);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition evaluation.

  logic [22:0] cond_d;

  // Every candidate condition is evaluated each cycle; the selector only picks one.
  always_comb begin
    cond_d     = '0;
    cond_d[0]  = speed_mag < zero_speed_threshold_q;
    cond_d[1]  = diff_mag <= (W+1)'(speed_match_band_q);
    cond_d[2]  = $signed(motor_speed_i) >= $signed(set_speed_q);
    cond_d[3]  = $signed(motor_current_i) > $signed(overload_sp_q);
    cond_d[4]  = $signed(motor_current_i) < $signed(underload_sp_q);
    cond_d[5]  = overload_left_i < W'(SOCS_OVL_FULL);
    cond_d[6]  = keypad_ctl_i;
    cond_d[7]  = brake_on_i;
    cond_d[8]  = foldback_i & vhz_mode_i;
    cond_d[9]  = fault_i;
    cond_d[10] = alarm_i;
    cond_d[11] = cmd_fwd_i;
    cond_d[12] = cmd_rev_i;
    cond_d[13] = ~motor_speed_i[W-1] & (motor_speed_i != '0);
    cond_d[14] = motor_speed_i[W-1];
    cond_d[15] = perr_mag > proc_tol_q;
    cond_d[16] = (pos_mag <= pos_tol_q) & (speed_mag <= zero_speed_threshold_q);
    cond_d[17] = (pos_mag > pos_tol_q) | (speed_mag > zero_speed_threshold_q);
    cond_d[18] = plc_out_i;
    cond_d[19] = rtc_s;
    cond_d[20] = bus_up_s & ~fault_i;
    cond_d[21] = heater_on_i;
    cond_d[22] = ct_close_q;
  end

  // Conditions are registered so the selector sees a glitch-free snapshot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output selection.

  logic out_d;

  // Codes outside the handled set, including 24, hold the output off.
  always_comb begin
    unique case (sel_q)
      SOCS_SEL_ZERO_SPD:  out_d = cond_q[0];
      SOCS_SEL_AT_SPD:    out_d = cond_q[1];
      SOCS_SEL_SET_SPD:   out_d = cond_q[2];
      SOCS_SEL_OVER_CUR:  out_d = cond_q[3];
      SOCS_SEL_UNDER_CUR: out_d = cond_q[4];
      SOCS_SEL_OVL_CAP:   out_d = cond_q[5];
      SOCS_SEL_KEYPAD:    out_d = cond_q[6];
      SOCS_SEL_BRAKE:     out_d = cond_q[7];
      SOCS_SEL_FOLDBACK:  out_d = cond_q[8];
      SOCS_SEL_FAULT:     out_d = cond_q[9];
      SOCS_SEL_ALARM:     out_d = cond_q[10];
      SOCS_SEL_CMD_FWD:   out_d = cond_q[11];
      SOCS_SEL_CMD_REV:   out_d = cond_q[12];
      SOCS_SEL_MOT_FWD:   out_d = cond_q[13];
      SOCS_SEL_MOT_REV:   out_d = cond_q[14];
      SOCS_SEL_PROC_ERR:  out_d = cond_q[15];
      SOCS_SEL_AT_POS:    out_d = cond_q[16];
      SOCS_SEL_IN_MOTION: out_d = cond_q[17];
      SOCS_SEL_PLC:       out_d = cond_q[18];
      SOCS_SEL_RTC:       out_d = cond_q[19];
      SOCS_SEL_BUS_UP:    out_d = cond_q[20];
      SOCS_SEL_HEATER:    out_d = cond_q[21];
      SOCS_SEL_CONTACTOR: out_d = cond_q[22];
      default:            out_d = 1'b0;
    endcase
  end

  // The output is recomputed every cycle from the one selected condition.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign out_o = out_q;

endmodule

/* socs_props.sv */
// Concurrent checks on the ports of the output condition selector.
`timescale 1ns/1ps
module socs_chk
  import socs_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [7:0]          adr_i,
  input wire logic [3:0]          sel_i,
  input wire logic [31:0]         dat_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  input wire logic signed [W-1:0] motor_speed_i,
  input wire logic                keypad_ctl_i,
  input wire logic                brake_on_i,
  input wire logic                foldback_i,
  input wire logic                vhz_mode_i,
  input wire logic                fault_i,
  input wire logic                alarm_i,
  input wire logic                cmd_fwd_i,
  input wire logic                cmd_rev_i,
  input wire logic                plc_out_i,
  input wire logic                heater_on_i,
  input wire logic                rtc_out_i,
  input wire logic                out_o,
  input wire logic                run_permit_o
);
  logic [4:0]   sel_q;
  logic [W-1:0] zero_q;
  logic [W-1:0] spd_mag;
  logic         wr_take;
  logic         simple_c;
  logic         exp_lvl;

  // A write lands on the edge where the slave first sees the request.
  assign wr_take = cyc_i && stb_i && we_i && !ack_o;
  assign spd_mag = motor_speed_i[W-1] ? W'(-motor_speed_i) : W'(motor_speed_i);

  // Shadow copies of the selection and zero-speed registers, kept from bus writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q  <= SOCS_SEL_RST;
      zero_q <= SOCS_THR_RST;
    end else if (wr_take && adr_i == SOCS_SEL_OFF && sel_i[0]) begin
      sel_q <= dat_i[4:0];
    end else if (wr_take && adr_i == SOCS_ZERO_OFF && sel_i == 4'hF) begin
      zero_q <= dat_i[W-1:0];
    end
  end

  // Codes that pass one status level straight through, foldback gated by vhz_mode_i; others are judged elsewhere.
  always_comb begin
    simple_c = 1'b1;
    exp_lvl  = 1'b0;
    case (sel_q)
      SOCS_SEL_KEYPAD:   exp_lvl = keypad_ctl_i;
      SOCS_SEL_BRAKE:    exp_lvl = brake_on_i;
      SOCS_SEL_FOLDBACK: exp_lvl = foldback_i && vhz_mode_i;
      SOCS_SEL_FAULT:    exp_lvl = fault_i;
      SOCS_SEL_ALARM:    exp_lvl = alarm_i;
      SOCS_SEL_CMD_FWD:  exp_lvl = cmd_fwd_i;
      SOCS_SEL_CMD_REV:  exp_lvl = cmd_rev_i;
      SOCS_SEL_PLC:      exp_lvl = plc_out_i;
      SOCS_SEL_HEATER:   exp_lvl = heater_on_i;
      default:           simple_c = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  ack_after_req_a: assert property (wb_req |=> ack_o)
    else $error("request not answered on the next edge");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("acknowledge without a request");
  unmapped_zero_a: assert property ((wb_req and (!we_i && adr_i == 8'h40)) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  simple_high_a:
    assert property ((simple_c && exp_lvl && $stable(sel_q))[*3] |-> out_o)
    else $error("output low while selected level is high");
  simple_low_a:
    assert property ((simple_c && !exp_lvl && $stable(sel_q))[*3] |-> !out_o)
    else $error("output high while selected level is low");
  refused_low_a:
    assert property (((sel_q < 5'h08 || sel_q == 5'h18) && $stable(sel_q))[*3] |-> !out_o)
    else $error("output high for an unused code");
  zero_speed_a:
    assert property ((sel_q == SOCS_SEL_ZERO_SPD && $stable(sel_q) && $stable(zero_q)
      && $stable(motor_speed_i))[*3] |-> out_o == (spd_mag < zero_q))
    else $error("zero speed output wrong");
  rtc_sync_a:
    assert property ((sel_q == SOCS_SEL_RTC && rtc_out_i && $stable(sel_q))[*5] |-> out_o)
    else $error("clock module level not passed through");
  permit_free_a:
    assert property ((sel_q != SOCS_SEL_CONTACTOR)[*2] |-> run_permit_o)
    else $error("run permit low without contactor selection");
endmodule

bind socs_top socs_chk #(.W(W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .motor_speed_i(motor_speed_i), .keypad_ctl_i(keypad_ctl_i), .brake_on_i(brake_on_i),
  .foldback_i(foldback_i), .vhz_mode_i(vhz_mode_i), .fault_i(fault_i), .alarm_i(alarm_i),
  .cmd_fwd_i(cmd_fwd_i), .cmd_rev_i(cmd_rev_i), .plc_out_i(plc_out_i),
  .heater_on_i(heater_on_i), .rtc_out_i(rtc_out_i), .out_o(out_o),
  .run_permit_o(run_permit_o)
);

/* socs_load.sv */
// Behavioural model of the relay coil wired to the programmable output.
`timescale 1ns/1ps
module socs_load (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic out_i,
  output int        closes_o
);
  logic out_q;

  // Counts contact closures, since a chattering output wears real contacts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q    <= 1'b0;
      closes_o <= 32'h0;
    end else begin
      out_q <= out_i;
      if (out_i && !out_q) begin
        closes_o <= closes_o + 32'h1;
      end
    end
  end
endmodule

/* socs_tb.sv */
// Self-checking testbench for the output condition selector.
`timescale 1ns/1ps
module testbench;
  import socs_pkg::*;

  logic               clk_i;
  logic               rst_i;
  logic               cyc_i;
  logic               stb_i;
  logic               we_i;
  logic        [7:0]  adr_i;
  logic        [3:0]  sel_i;
  logic        [31:0] dat_i;
  logic        [31:0] dat_o;
  logic               ack_o;
  logic signed [15:0] spd, cmd, cur, perr, pos;
  logic        [15:0] ovl;
  logic               keypad, brake, fold, vhz, fault, alarm, fwd, rev, plc, heat, drun, rtc, bus;
  logic               out_o;
  logic               run_permit_o;
  int                 closes;
  int                 err_total;
  int                 n_checks;

  socs_top #(.W(16), .CONT_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .motor_speed_i(spd), .speed_cmd_i(cmd), .motor_current_i(cur),
    .process_err_i(perr), .position_err_i(pos), .overload_left_i(ovl),
    .keypad_ctl_i(keypad), .brake_on_i(brake), .foldback_i(fold), .vhz_mode_i(vhz),
    .fault_i(fault), .alarm_i(alarm), .cmd_fwd_i(fwd), .cmd_rev_i(rev),
    .plc_out_i(plc), .heater_on_i(heat), .drive_run_i(drun), .rtc_out_i(rtc),
    .bus_up_i(bus), .out_o(out_o), .run_permit_o(run_permit_o)
  );
  socs_load load (.clk_i(clk_i), .rst_i(rst_i), .out_i(out_o), .closes_o(closes));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One classic cycle; the request is held until acknowledge is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Output is registered twice, so a settled input shows on the third edge.
  task automatic oc(input logic e, input string m);
    repeat (3) @(posedge clk_i);
    chk({31'h0, out_o}, {31'h0, e}, m);
  endtask

  task automatic sc(input logic [4:0] c, input logic e, input string m);
    wr(SOCS_SEL_OFF, {27'h0, c});
    oc(e, m);
  endtask

  task automatic lv(input logic v);
    @(posedge clk_i);
    {keypad, brake, fold, fault, alarm, fwd, rev, plc, heat, drun, rtc, bus} <= {12{v}};
  endtask

  task automatic drv(input logic [4:0] c, input logic v);
    @(posedge clk_i);
    case (c)
      SOCS_SEL_KEYPAD:   keypad <= v;
      SOCS_SEL_BRAKE:    brake <= v;
      SOCS_SEL_FOLDBACK: fold <= v;
      SOCS_SEL_FAULT:    fault <= v;
      SOCS_SEL_ALARM:    alarm <= v;
      SOCS_SEL_CMD_FWD:  fwd <= v;
      SOCS_SEL_CMD_REV:  rev <= v;
      SOCS_SEL_PLC:      plc <= v;
      default:           heat <= v;
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, SOCS_SEL_OFF, 32'h0, q);
    chk(q, 32'h0, "selection reset");
    wr(SOCS_ZERO_OFF, 32'hABCD1234);
    wb(1'b0, SOCS_ZERO_OFF, 32'h0, q);
    chk(q, 32'h00001234, "threshold readback");
    wr(8'h40, 32'h00000005);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    wb(1'b0, SOCS_STAT_OFF, 32'h0, q);
    chk(q, 32'h2, "status after reset");
  endtask

  task automatic t_levels;
    logic [4:0] c [9];
    c = '{SOCS_SEL_KEYPAD, SOCS_SEL_BRAKE, SOCS_SEL_FOLDBACK, SOCS_SEL_FAULT, SOCS_SEL_ALARM,
          SOCS_SEL_CMD_FWD, SOCS_SEL_CMD_REV, SOCS_SEL_PLC, SOCS_SEL_HEATER};
    vhz <= 1'b1;
    foreach (c[i]) begin
      wr(SOCS_SEL_OFF, {27'h0, c[i]});
      drv(c[i], 1'b1);
      oc(1'b1, "level high");
      drv(c[i], 1'b0);
      oc(1'b0, "level low");
    end
  endtask

  // Each vector sits on or next to a threshold; one bit per code in table order.
  task automatic t_numeric;
    logic [4:0]  nc [11];
    logic [95:0] vec [3];
    logic [10:0] ex [3];
    nc = '{SOCS_SEL_ZERO_SPD, SOCS_SEL_AT_SPD, SOCS_SEL_SET_SPD, SOCS_SEL_OVER_CUR,
           SOCS_SEL_UNDER_CUR, SOCS_SEL_OVL_CAP, SOCS_SEL_MOT_FWD, SOCS_SEL_MOT_REV,
           SOCS_SEL_PROC_ERR, SOCS_SEL_AT_POS, SOCS_SEL_IN_MOTION};
    vec = '{96'hFFF7_0064_0014_0008_0003_0064, 96'h0032_0035_0015_FFF9_FFFC_0063,
            96'h000A_000F_0013_FFF8_0000_0064};
    ex = '{11'h40E, 11'h3B1, 11'h256};
    wr(SOCS_ZERO_OFF, 32'h0000000A);
    wr(SOCS_BAND_OFF, 32'h00000005);
    wr(SOCS_SETPT_OFF, 32'h00000032);
    wr(SOCS_OVLD_OFF, 32'h00000014);
    wr(SOCS_UNLD_OFF, 32'h00000014);
    wr(SOCS_PERR_OFF, 32'h00000007);
    wr(SOCS_POSTOL_OFF, 32'h00000003);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      {spd, cmd, cur, perr, pos, ovl} <= vec[k];
      for (int i = 0; i < 11; i++) begin
        sc(nc[i], ex[k][10-i], "threshold code");
      end
    end
  endtask

  task automatic t_refused;
    lv(1'b1);
    vhz <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      sc(5'(c), 1'b0, "unused code");
    end
    sc(5'h18, 1'b0, "network code");
    sc(SOCS_SEL_FOLDBACK, 1'b0, "foldback outside volts per hertz");
    vhz <= 1'b1;
    oc(1'b1, "foldback in volts per hertz");
  endtask

  task automatic t_sync;
    sc(SOCS_SEL_RTC, 1'b1, "clock module path");
    sc(SOCS_SEL_BUS_UP, 1'b0, "bus up with fault");
    drv(SOCS_SEL_FAULT, 1'b0);
    oc(1'b1, "bus up without fault");
    @(posedge clk_i);
    bus <= 1'b0;
    repeat (2) @(posedge clk_i);
    oc(1'b0, "bus down");
  endtask

  task automatic t_contactor;
    int          c0;
    logic [31:0] q;
    lv(1'b0);
    repeat (8) @(posedge clk_i);
    sc(SOCS_SEL_CONTACTOR, 1'b0, "contactor idle");
    chk({31'h0, run_permit_o}, 32'h0, "permit while open");
    c0 = closes;
    drv(SOCS_SEL_CMD_FWD, 1'b1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, run_permit_o}, 32'h0, "permit before settle");
    oc(1'b1, "contactor pulls in");
    repeat (10) @(posedge clk_i);
    chk({31'h0, run_permit_o}, 32'h1, "permit after settle");
    wb(1'b0, SOCS_STAT_OFF, 32'h0, q);
    chk(q, 32'h3, "status closed");
    drun <= 1'b1;
    drv(SOCS_SEL_CMD_FWD, 1'b0);
    oc(1'b1, "contactor trails stop");
    repeat (10) @(posedge clk_i);
    oc(1'b1, "held while drive runs");
    drun <= 1'b0;
    repeat (10) @(posedge clk_i);
    oc(1'b0, "contactor drops");
    chk(32'(closes - c0), 32'h1, "one closure");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 20 MHz.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // The whole run needs well under two thousand cycles, so this only cuts a hang.
  initial begin
    repeat (8000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    err_total = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {spd, cmd, cur, perr, pos, ovl, vhz} = '0;
    {keypad, brake, fold, fault, alarm, fwd, rev, plc, heat, drun, rtc, bus} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_levels();
    t_numeric();
    t_refused();
    t_sync();
    t_contactor();
    tally_and_finish();
  end
endmodule
